// ==== shared/codec_ctl_pkg.sv ====
package codec_ctl_pkg;

    // -------------------------------------------------------------------
    // Register addresses
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_DAC1_OUTPUT_GAIN = 8'h04;
    localparam logic [7:0] ADDR_CODEC1_ANALOG_ROUTING = 8'h05;
    localparam logic [7:0] ADDR_CODEC2_RESERVED_CONFIG = 8'h06;
    localparam logic [7:0] ADDR_CODEC2_MODE_CONTROL = 8'h07;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [5:0] RST_DAC1_OUTPUT_GAIN = 6'h00;
    localparam logic [7:0] RST_CODEC1_ANALOG_ROUTING = 8'h84;
    localparam logic [7:0] RST_CODEC2_RESERVED_CONFIG = 8'h50;
    localparam logic [7:0] RST_CODEC2_MODE_CONTROL = 8'h50;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // -------------------------------------------------------------------
    // Field layout
    // -------------------------------------------------------------------
    localparam int GAIN_CODE_W = 6;
    localparam int BIT_HANDSET_IN = 7;
    localparam int BIT_HEADSET_IN = 6;
    localparam int BIT_MICROPHONE_IN = 5;
    localparam int BIT_LINE_IN = 4;
    localparam int BIT_CALLERID_IN = 3;
    localparam int BIT_HANDSET_OUT = 2;
    localparam int BIT_HEADSET_OUT = 1;
    localparam int BIT_SPEAKER_OUT = 0;
    localparam int INTERP_MSB = 7;
    localparam int INTERP_LSB = 4;
    localparam int BIT_ANALOG_LOOPBACK = 3;
    localparam int BIT_DIGITAL_LOOPBACK = 2;
    localparam int BIT_POWER_DOWN = 1;
    localparam int BIT_SW_RESET = 0;

    // -------------------------------------------------------------------
    // Gain code map, gain in half-dB units
    // -------------------------------------------------------------------
    localparam logic [5:0] GAIN_CODE_MUTE = 6'h30;
    localparam logic [5:0] GAIN_CODE_ZERO = 6'h00;
    localparam logic [5:0] GAIN_CODE_0DB = 6'h19;
    localparam logic [5:0] GAIN_CODE_MAX = 6'h21;
    localparam logic signed [7:0] GAIN_STEP_HALF_DB = 8'sh03;
    localparam logic signed [7:0] GAIN_MAX_HALF_DB = 8'sh18;
    localparam logic signed [7:0] GAIN_0DB_HALF_DB = 8'sh00;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SAMPLE_PERIOD_8K_PS = 125000000;
    localparam int SAMPLE_PERIOD_16K_PS = 62500000;
    // Longest time: round down
    localparam int SAMPLE_CYCLES_8K = SAMPLE_PERIOD_8K_PS / CLK_PERIOD_PS;
    localparam int SAMPLE_CYCLES_16K = SAMPLE_PERIOD_16K_PS / CLK_PERIOD_PS;
    localparam int SAMPLE_CNT_W = 16;

endpackage : codec_ctl_pkg

// ==== hw/dac_gain_stage.sv ====
`timescale 1ns/10ps
module dac_gain_stage
    import codec_ctl_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_load,
    input wire logic [GAIN_CODE_W-1:0] i_code,
    output logic signed [7:0] o_gain_half_db,
    output logic o_mute
);

    // -------------------------------------------------------------------
    // Code to gain
    // -------------------------------------------------------------------
    function automatic logic signed [7:0] code_to_half_db(input logic [GAIN_CODE_W-1:0] code);
        logic signed [7:0] steps;
        steps = $signed({2'b00, code}) - $signed({2'b00, GAIN_CODE_0DB});
        if (code == GAIN_CODE_ZERO) begin
            code_to_half_db = GAIN_0DB_HALF_DB;
        end else if (code > GAIN_CODE_MAX) begin
            // Undefined codes saturate at the top step
            code_to_half_db = GAIN_MAX_HALF_DB;
        end else begin
            code_to_half_db = 8'(steps * GAIN_STEP_HALF_DB);
        end
    endfunction : code_to_half_db

    wire logic signed [7:0] gain_next = code_to_half_db(i_code);
    wire logic mute_next = (i_code == GAIN_CODE_MUTE);

    logic signed [7:0] gain_reg;
    logic mute_reg;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gain_reg <= GAIN_0DB_HALF_DB;
            mute_reg <= 1'b0;
        end else if (i_load) begin
            gain_reg <= gain_next;
            mute_reg <= mute_next;
        end
    end

    assign o_gain_half_db = gain_reg;
    assign o_mute = mute_reg;

endmodule : dac_gain_stage

// ==== hw/codec_gain_routing_control_regs.sv ====
// What this block does
// - Address 04 holds DAC1 gain in low six bits; 110000 mutes; resets to zero.
// - Code 100001 is +12 dB, down 1.5 dB per step to -36 dB at 000001.
// - Gain code zero gives 0 dB, same as code 011001.
// - Routing register D7..D3 select handset, headset, mic, line, caller-ID inputs.
// - Routing register D2..D0 connect codec 1 to handset, headset, speaker outputs.
// - Routing register resets to 1000 0100: handset in and handset out.
// - Mode register D7..D4 hold interpolation minus one; reset means six.
// - Mode register D3 enables codec 2 analog loopback.
// - Mode register D2 enables codec 2 digital loopback.
// - Mode register D1 powers codec 2 down.
// - Writing 1 to mode D0 resets the codec 2 registers to defaults.
// - Codec 1 software reset restores gain and routing registers.
// - Without simultaneous update, new gain applies within one sample period.
`timescale 1ns/10ps
module codec_gain_routing_control_regs
    import codec_ctl_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES_8K_P = SAMPLE_CYCLES_8K,
    parameter int unsigned SAMPLE_CYCLES_16K_P = SAMPLE_CYCLES_16K
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_codec1_sw_reset,
    input wire logic i_sim_update,
    input wire logic i_gain_commit,
    input wire logic i_rate_16k,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic signed [7:0] o_dac1_gain_half_db,
    output logic o_dac1_mute,
    output logic o_handset_in_sel,
    output logic o_headset_in_sel,
    output logic o_microphone_in_sel,
    output logic o_line_in_sel,
    output logic o_callerid_in_sel,
    output logic o_handset_out_sel,
    output logic o_headset_out_sel,
    output logic o_speaker_out_sel,
    output logic [3:0] o_codec2_interp_minus1,
    output logic o_codec2_analog_loopback,
    output logic o_codec2_digital_loopback,
    output logic o_codec2_power_down,
    output logic o_codec2_sw_reset
);

    // -------------------------------------------------------------------
    // Parameter checks
    // -------------------------------------------------------------------
    if (SAMPLE_CYCLES_8K_P < 1 || SAMPLE_CYCLES_16K_P < 1 ||
        SAMPLE_CYCLES_8K_P > (1 << SAMPLE_CNT_W) || SAMPLE_CYCLES_16K_P > (1 << SAMPLE_CNT_W)) begin : g_bad_period
        $error("Sample period cycles out of range");
    end

    // Latency bound is one 8 kHz period, so the 16 kHz period must not exceed it
    if (SAMPLE_CYCLES_16K_P > SAMPLE_CYCLES_8K_P) begin : g_bad_rate_order
        $error("16 kHz period longer than 8 kHz period");
    end

    localparam logic [SAMPLE_CNT_W-1:0] RELOAD_8K = SAMPLE_CNT_W'(SAMPLE_CYCLES_8K_P - 1);
    localparam logic [SAMPLE_CNT_W-1:0] RELOAD_16K = SAMPLE_CNT_W'(SAMPLE_CYCLES_16K_P - 1);
    localparam logic [SAMPLE_CNT_W-1:0] CNT_ZERO = '0;

    // -------------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------------
    wire logic hit_gain = (i_addr == ADDR_DAC1_OUTPUT_GAIN);
    wire logic hit_route = (i_addr == ADDR_CODEC1_ANALOG_ROUTING);
    wire logic hit_rsvd = (i_addr == ADDR_CODEC2_RESERVED_CONFIG);
    wire logic hit_mode = (i_addr == ADDR_CODEC2_MODE_CONTROL);

    wire logic wr_gain = i_wr_en && hit_gain;
    wire logic wr_route = i_wr_en && hit_route;
    wire logic wr_mode = i_wr_en && hit_mode;
    wire logic codec2_reset = wr_mode && i_wr_data[BIT_SW_RESET];

    // -------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------
    logic [GAIN_CODE_W-1:0] gain_reg;
    logic [7:0] route_reg;
    logic [7:0] rsvd_reg;
    logic [7:0] mode_reg;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    logic sw_reset_pulse_reg;
    logic pending_reg;
    logic tick_reg;
    logic [SAMPLE_CNT_W-1:0] cnt_reg;

    // -------------------------------------------------------------------
    // Gain apply control
    // -------------------------------------------------------------------
    // Codec 1 reset counts as a write so the applied gain follows
    wire logic gain_changed = wr_gain || i_codec1_sw_reset;
    wire logic gain_apply = pending_reg && (i_sim_update ? i_gain_commit : tick_reg);
    // A write in the apply cycle keeps the flag set
    wire logic pending_next = gain_changed || (pending_reg && !gain_apply);

    wire logic [SAMPLE_CNT_W-1:0] reload = i_rate_16k ? RELOAD_16K : RELOAD_8K;
    wire logic cnt_done = (cnt_reg == CNT_ZERO);
    wire logic [SAMPLE_CNT_W-1:0] cnt_next = cnt_done ? reload : cnt_reg - 1'b1;

    // -------------------------------------------------------------------
    // Read mux
    // -------------------------------------------------------------------
    // A read in the cycle of a write to the same address returns the old value
    // Unused upper bits of gain are never stored and read as zero
    wire logic [7:0] gain_read = {{(8 - GAIN_CODE_W){1'b0}}, gain_reg};
    wire logic [7:0] rd_data_next =
        hit_gain ? gain_read :
        hit_route ? route_reg :
        hit_rsvd ? rsvd_reg :
        hit_mode ? mode_reg : READ_UNMAPPED;

    // -------------------------------------------------------------------
    // Codec 1 registers
    // -------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gain_reg <= RST_DAC1_OUTPUT_GAIN;
            route_reg <= RST_CODEC1_ANALOG_ROUTING;
        end else if (i_codec1_sw_reset) begin
            gain_reg <= RST_DAC1_OUTPUT_GAIN;
            route_reg <= RST_CODEC1_ANALOG_ROUTING;
        end else begin
            if (wr_gain) begin
                gain_reg <= i_wr_data[GAIN_CODE_W-1:0];
            end
            if (wr_route) begin
                route_reg <= i_wr_data;
            end
        end
    end

    // -------------------------------------------------------------------
    // Codec 2 registers
    // -------------------------------------------------------------------
    // Reserved register ignores writes so a stray write cannot break codec 2
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rsvd_reg <= RST_CODEC2_RESERVED_CONFIG;
            mode_reg <= RST_CODEC2_MODE_CONTROL;
            sw_reset_pulse_reg <= 1'b0;
        end else begin
            sw_reset_pulse_reg <= codec2_reset;
            if (codec2_reset) begin
                rsvd_reg <= RST_CODEC2_RESERVED_CONFIG;
                mode_reg <= RST_CODEC2_MODE_CONTROL;
            end else if (wr_mode) begin
                mode_reg <= i_wr_data;
            end
        end
    end

    // -------------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_data_reg <= READ_UNMAPPED;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= i_rd_en;
            if (i_rd_en) begin
                rd_data_reg <= rd_data_next;
            end
        end
    end

    // -------------------------------------------------------------------
    // Sample timer and gain apply
    // -------------------------------------------------------------------
    // Free-running; a rate change takes effect at the next reload
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_reg <= RELOAD_8K;
            tick_reg <= 1'b0;
            pending_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= cnt_done;
            pending_reg <= pending_next;
        end
    end

    // -------------------------------------------------------------------
    // Applied gain
    // -------------------------------------------------------------------
    // Decoded gain is registered so it moves only on an apply
    dac_gain_stage i_dac_gain_stage (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_load(gain_apply),
        .i_code(gain_reg),
        .o_gain_half_db(o_dac1_gain_half_db),
        .o_mute(o_dac1_mute)
    );

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign o_rd_data = rd_data_reg;
    assign o_rd_valid = rd_valid_reg;
    assign o_handset_in_sel = route_reg[BIT_HANDSET_IN];
    assign o_headset_in_sel = route_reg[BIT_HEADSET_IN];
    assign o_microphone_in_sel = route_reg[BIT_MICROPHONE_IN];
    assign o_line_in_sel = route_reg[BIT_LINE_IN];
    assign o_callerid_in_sel = route_reg[BIT_CALLERID_IN];
    assign o_handset_out_sel = route_reg[BIT_HANDSET_OUT];
    assign o_headset_out_sel = route_reg[BIT_HEADSET_OUT];
    assign o_speaker_out_sel = route_reg[BIT_SPEAKER_OUT];
    assign o_codec2_interp_minus1 = mode_reg[INTERP_MSB:INTERP_LSB];
    assign o_codec2_analog_loopback = mode_reg[BIT_ANALOG_LOOPBACK];
    assign o_codec2_digital_loopback = mode_reg[BIT_DIGITAL_LOOPBACK];
    assign o_codec2_power_down = mode_reg[BIT_POWER_DOWN];
    assign o_codec2_sw_reset = sw_reset_pulse_reg;

endmodule : codec_gain_routing_control_regs

// ==== sim/codec_regs_chk_sva.sv ====
`timescale 1ns/10ps
module codec_regs_chk
    import codec_ctl_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES_8K_P = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_codec1_sw_reset,
    input wire logic i_sim_update,
    input wire logic i_gain_commit,
    input wire logic [7:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic signed [7:0] o_dac1_gain_half_db,
    input wire logic o_dac1_mute,
    input wire logic o_handset_in_sel,
    input wire logic o_headset_in_sel,
    input wire logic o_microphone_in_sel,
    input wire logic o_line_in_sel,
    input wire logic o_callerid_in_sel,
    input wire logic o_handset_out_sel,
    input wire logic o_headset_out_sel,
    input wire logic o_speaker_out_sel,
    input wire logic [3:0] o_codec2_interp_minus1,
    input wire logic o_codec2_analog_loopback,
    input wire logic o_codec2_digital_loopback,
    input wire logic o_codec2_power_down,
    input wire logic o_codec2_sw_reset
);
    // ---------------------------------------------
    // Gain apply window tracker
    // ---------------------------------------------
    // 8 kHz is the longer period, so one bound covers both rates
    localparam int LIM = SAMPLE_CYCLES_8K_P + 4;
    wire logic [7:0] route_w = {o_handset_in_sel, o_headset_in_sel, o_microphone_in_sel, o_line_in_sel,
        o_callerid_in_sel, o_handset_out_sel, o_headset_out_sel, o_speaker_out_sel};
    wire logic [6:0] mode_w = {o_codec2_interp_minus1, o_codec2_analog_loopback, o_codec2_digital_loopback,
        o_codec2_power_down};
    wire logic [5:0] code_w = i_wr_data[5:0];
    wire logic gain_wr = i_wr_en && i_addr == ADDR_DAC1_OUTPUT_GAIN && !i_sim_update && !i_codec1_sw_reset;
    wire logic code_ok = code_w <= GAIN_CODE_MAX || code_w == GAIN_CODE_MUTE;
    wire logic rst2_wr = i_wr_en && i_addr == ADDR_CODEC2_MODE_CONTROL && i_wr_data[0];
    int cnt_q;
    logic signed [7:0] exp_q;
    logic mute_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) cnt_q <= 0;
        else if (gain_wr) cnt_q <= code_ok ? 1 : 0;
        else if (i_codec1_sw_reset || i_sim_update || cnt_q == LIM) cnt_q <= 0;
        else if (cnt_q != 0) cnt_q <= cnt_q + 1;
    end
    always_ff @(posedge i_clk_sys) begin
        if (gain_wr) begin
            exp_q <= (code_w == GAIN_CODE_ZERO) ? 8'sh00 : 8'sh03 * ($signed({2'b00, code_w}) - 8'sh19);
            mute_q <= code_w == GAIN_CODE_MUTE;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    sequence s_mode_wr(d0);
        i_wr_en && i_addr == ADDR_CODEC2_MODE_CONTROL && i_wr_data[0] == d0;
    endsequence
    AST_RD_GAIN: assert property (i_rd_en && i_addr == ADDR_DAC1_OUTPUT_GAIN |=>
        o_rd_valid && o_rd_data[7:6] == 2'b00) else $error("gain upper bits read nonzero");
    AST_ROUTE_WR: assert property (i_wr_en && i_addr == ADDR_CODEC1_ANALOG_ROUTING && !i_codec1_sw_reset |=>
        route_w == $past(i_wr_data)) else $error("routing outputs differ from write");
    AST_ROUTE_RST: assert property (i_codec1_sw_reset |=> route_w == 8'h84)
        else $error("routing not default after codec 1 reset");
    AST_MODE_WR: assert property (s_mode_wr(1'b0) |=> mode_w == $past(i_wr_data[7:1]) && !o_codec2_sw_reset)
        else $error("mode outputs differ from write");
    AST_MODE_RST: assert property (s_mode_wr(1'b1) |=> o_codec2_sw_reset && mode_w == 7'h28)
        else $error("codec 2 reset did not restore mode");
    AST_RST2_CAUSE: assert property (o_codec2_sw_reset |-> $past(rst2_wr))
        else $error("codec 2 reset pulse without cause");
    AST_HOLD: assert property (i_sim_update && !i_gain_commit |=> $stable(o_dac1_gain_half_db) && $stable(o_dac1_mute))
        else $error("gain moved without commit");
    AST_GAIN_APPLY: assert property (cnt_q == LIM |-> o_dac1_mute == mute_q && (mute_q || o_dac1_gain_half_db == exp_q))
        else $error("gain not applied in one sample period");
endmodule : codec_regs_chk
bind codec_gain_routing_control_regs codec_regs_chk #(.SAMPLE_CYCLES_8K_P(SAMPLE_CYCLES_8K_P)) i_codec_regs_chk (.*);

// ==== sim/dsp_ctl_host.sv ====
`timescale 1ns/10ps
module dsp_ctl_host
    import codec_ctl_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wr_data
);
    initial {o_wr_en, o_rd_en, o_addr, o_wr_data} = 18'h00000;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_wr_en <= (a != ADDR_CODEC2_RESERVED_CONFIG);
        o_addr <= a;
        o_wr_data <= d;
        @(posedge i_clk_sys);
        o_wr_en <= 1'b0;
        // Stale bus shows inverted values, not the last ones
        o_addr <= ~a;
        o_wr_data <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge i_clk_sys);
        o_rd_en <= 1'b1;
        o_addr <= a;
        @(posedge i_clk_sys);
        o_rd_en <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rd_data;
        v = i_rd_valid;
    endtask : rd
endmodule : dsp_ctl_host

// ==== sim/codec_gain_routing_control_regs_tb_top.sv ====
`timescale 1ns/10ps
module codec_gain_routing_control_regs_tb_top;
    import codec_ctl_pkg::*;
    // ---------------------------------------------
    // Bench
    // ---------------------------------------------
    localparam int unsigned S8 = 8;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic c1_rst = 1'b0, sim_upd = 1'b0, commit = 1'b0, rate16 = 1'b0;
    logic wr_en, rd_en, rval, mute, sw2;
    logic [7:0] addr, wdat, rdat, gain;
    // Driven bit by bit from separate output ports
    wire logic [7:0] route;
    wire logic [6:0] mode;
    int error_cnt = 0, num_checks = 0;
    logic [7:0] mode_tbl [6] = '{8'h08, 8'h04, 8'h02, 8'hf0, 8'h00, 8'h0e};
    logic [5:0] gain_tbl [7] = '{6'h21, 6'h20, 6'h01, 6'h00, 6'h19, 6'h30, 6'h18};
    always #2 i_clk_sys = ~i_clk_sys;
    codec_gain_routing_control_regs #(.SAMPLE_CYCLES_8K_P(S8), .SAMPLE_CYCLES_16K_P(S8 / 2))
    i_codec_gain_routing_control_regs (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_wr_en(wr_en),
        .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wdat), .i_codec1_sw_reset(c1_rst), .i_sim_update(sim_upd),
        .i_gain_commit(commit), .i_rate_16k(rate16), .o_rd_data(rdat), .o_rd_valid(rval),
        .o_dac1_gain_half_db(gain), .o_dac1_mute(mute), .o_handset_in_sel(route[7]), .o_headset_in_sel(route[6]),
        .o_microphone_in_sel(route[5]), .o_line_in_sel(route[4]), .o_callerid_in_sel(route[3]),
        .o_handset_out_sel(route[2]), .o_headset_out_sel(route[1]), .o_speaker_out_sel(route[0]),
        .o_codec2_interp_minus1(mode[6:3]), .o_codec2_analog_loopback(mode[2]),
        .o_codec2_digital_loopback(mode[1]), .o_codec2_power_down(mode[0]), .o_codec2_sw_reset(sw2));
    dsp_ctl_host i_dsp_ctl_host (.i_clk_sys(i_clk_sys), .i_rd_data(rdat), .i_rd_valid(rval),
        .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wdat));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        i_dsp_ctl_host.rd(a, d, v);
        check({7'h00, v}, 8'h01);
        check(d, exp);
    endtask : rdc
    task automatic apply();
        @(posedge i_clk_sys) commit <= 1'b1;
        @(posedge i_clk_sys) commit <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
    endtask : apply
    function automatic logic [7:0] eh(input logic [5:0] c);
        return (c == 6'h00) ? 8'h00 : 8'(({2'b00, c} - 8'd25) * 8'd3);
    endfunction : eh
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        rdc(ADDR_DAC1_OUTPUT_GAIN, 8'h00);
        rdc(ADDR_CODEC1_ANALOG_ROUTING, 8'h84);
        rdc(ADDR_CODEC2_RESERVED_CONFIG, 8'h50);
        rdc(ADDR_CODEC2_MODE_CONTROL, 8'h50);
        rdc(8'h08, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            i_dsp_ctl_host.wr(ADDR_CODEC1_ANALOG_ROUTING, 8'h01 << i);
            #1 check(route, 8'h01 << i);
        end
        rdc(ADDR_CODEC1_ANALOG_ROUTING, 8'h80);
        $display("routing test done");
        foreach (mode_tbl[i]) begin
            i_dsp_ctl_host.wr(ADDR_CODEC2_MODE_CONTROL, mode_tbl[i]);
            #1 check({1'b0, mode}, {1'b0, mode_tbl[i][7:1]});
            rdc(ADDR_CODEC2_MODE_CONTROL, mode_tbl[i]);
        end
        i_dsp_ctl_host.wr(ADDR_CODEC2_MODE_CONTROL, 8'h01);
        #1 check({7'h00, sw2}, 8'h01);
        check({1'b0, mode}, 8'h28);
        rdc(ADDR_CODEC2_MODE_CONTROL, 8'h50);
        rdc(ADDR_CODEC1_ANALOG_ROUTING, 8'h80);
        $display("mode test done");
        foreach (gain_tbl[i]) begin
            @(posedge i_clk_sys) rate16 <= 1'(i);
            i_dsp_ctl_host.wr(ADDR_DAC1_OUTPUT_GAIN, {2'b11, gain_tbl[i]});
            repeat (S8 + 4) @(posedge i_clk_sys);
            #1 check({7'h00, mute}, {7'h00, gain_tbl[i] == 6'h30});
            if (gain_tbl[i] != 6'h30) check(gain, eh(gain_tbl[i]));
            rdc(ADDR_DAC1_OUTPUT_GAIN, {2'b00, gain_tbl[i]});
        end
        @(posedge i_clk_sys) sim_upd <= 1'b1;
        i_dsp_ctl_host.wr(ADDR_DAC1_OUTPUT_GAIN, 8'h21);
        repeat (3 * S8) @(posedge i_clk_sys);
        #1 check(gain, eh(6'h18));
        apply();
        #1 check(gain, 8'h18);
        $display("gain test done");
        @(posedge i_clk_sys) c1_rst <= 1'b1;
        @(posedge i_clk_sys) c1_rst <= 1'b0;
        rdc(ADDR_CODEC1_ANALOG_ROUTING, 8'h84);
        rdc(ADDR_DAC1_OUTPUT_GAIN, 8'h00);
        apply();
        #1 check(gain, 8'h00);
        $display("codec 1 reset test done");
        summarize();
    end
endmodule : codec_gain_routing_control_regs_tb_top
